// ---- adc_scan_sequencer_avg_limits_tb_top.sv ----
/*
  Self-checking bench for the scan sequencer with a behavioural core.
  Assumes the core model answers each convStart exactly once.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module adc_scan_sequencer_avg_limits_tb_top
  import scan_pkg::*;
();
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic scanStart = 1'b0;
  logic continuous = 1'b0;
  logic [CH_W-1:0] lastChannel = 4'h0;
  logic [NUM_CH-1:0] chanEnable = 16'h0001;
  logic [NUM_CH-1:0] chanAltRes = 16'h0000;
  logic [NUM_CH-1:0] chanDiff = 16'h0000;
  logic [NUM_CH-1:0] chanAvg = 16'h0000;
  logic [NUM_CH-1:0] limitIrqEn = 16'h0001;
  logic [NUM_CH-1:0] satIrqEn = 16'h0001;
  logic [NUM_CH*ACQ_W-1:0] acqTimeNs = {16{16'h0064}};
  logic alternate_resolution_select = 1'b0;
  logic [AVG_W-1:0] avgCount = 9'h002;
  logic avgCountLoad = 1'b0;
  logic [1:0] avgMode = 2'h1;
  logic diffSigned = 1'b0;
  logic seSigned = 1'b0;
  logic [1:0] cmpMode = 2'h0;
  logic [RES_W-1:0] lowLimitIn = 16'h0200;
  logic [RES_W-1:0] highLimitIn = 16'h0E00;
  logic limitLoad = 1'b0;
  logic [CH_W-1:0] readChannel = 4'h0;
  logic [3:0] latency = 4'h0;
  logic [11:0] chanCode [NUM_CH] = '{default: 12'h000};
  logic convDone, convStart, muxDiff, sampling, busy, endOfScan;
  logic rangeEvent, satEvent;
  logic [11:0] convCode;
  logic [CH_W-1:0] muxChannel, eventChannel;
  logic [1:0] convBits;
  logic [NUM_CH-1:0] chanValid;
  logic [RES_W-1:0] readResult, r, lo, hi, ex;
  logic [11:0] c;
  logic [11:0] corner [6] = '{12'h1FF, 12'h200, 12'hDFF, 12'hE00, 12'h000,
    12'hFFF};
  int mismatches, n_checks, nEos, nRange, nSat, acqRun, acqMin, cycles, n;
  logic [CH_W-1:0] convCh [$];
  logic [1:0] bitsSeen [$];
  logic diffSeen [$];

  scan_sequencer i_scan_sequencer (.clk_sys, .arst_n, .scanStart,
    .continuous, .lastChannel, .chanEnable, .chanAltRes, .chanDiff, .chanAvg,
    .limitIrqEn, .satIrqEn, .acqTimeNs, .alternate_resolution_select,
    .avgCount, .avgCountLoad, .avgMode, .diffSigned, .seSigned, .cmpMode,
    .lowLimitIn, .highLimitIn, .limitLoad, .convDone, .convCode, .readChannel,
    .convStart, .muxChannel, .muxDiff, .sampling, .convBits, .busy,
    .endOfScan, .rangeEvent, .satEvent, .eventChannel, .chanValid,
    .readResult);
  conv_core_model i_conv_core_model (.clk_sys, .arst_n, .convStart,
    .muxChannel, .latency, .chanCode, .convDone, .convCode);

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      report_and_stop();
    end
    nEos += int'(endOfScan === 1'b1);
    nRange += int'(rangeEvent === 1'b1);
    nSat += int'(satEvent === 1'b1);
    acqRun += int'(sampling === 1'b1);
    if (convStart === 1'b1) begin
      convCh.push_back(muxChannel);
      bitsSeen.push_back(convBits);
      diffSeen.push_back(muxDiff);
      if (acqRun < acqMin) acqMin = acqRun;
      acqRun = 0;
    end
  end

  function automatic int hit(logic [15:0] v, l, h, logic [1:0] m);
    case (m)
      2'h0: return int'(v < l);
      2'h1: return int'(v >= l && v < h);
      2'h2: return int'(v >= h);
      default: return int'(v < l || v >= h);
    endcase
  endfunction : hit

  task automatic do_reset();
    @(negedge clk_sys);
    arst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    lo = 16'h0200;
    hi = 16'h0E00;
  endtask : do_reset

  task automatic load_cfg(input int cnt);
    @(negedge clk_sys);
    avgCount = AVG_W'(cnt);
    lowLimitIn = lo;
    highLimitIn = hi;
    avgCountLoad = 1'b1;
    limitLoad = 1'b1;
    @(negedge clk_sys);
    avgCountLoad = 1'b0;
    limitLoad = 1'b0;
  endtask : load_cfg

  task automatic run_scan();
    int k;
    nEos = 0;
    nRange = 0;
    nSat = 0;
    acqMin = 9999;
    acqRun = 0;
    convCh.delete();
    bitsSeen.delete();
    diffSeen.delete();
    @(negedge clk_sys) scanStart = 1'b1;
    @(negedge clk_sys) scanStart = 1'b0;
    @(negedge clk_sys);
    for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge clk_sys);
    repeat (3) @(negedge clk_sys);
  endtask : run_scan

  task automatic read_res(input logic [CH_W-1:0] ch);
    readChannel = ch;
    repeat (2) @(negedge clk_sys);
    r = readResult;
  endtask : read_res

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  initial begin
    void'($urandom(32'h279D));
    do_reset();
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        for (int k = 0; k < 7; k++) begin
          c = (k < 6) ? corner[k] : 12'($urandom);
          chanCode[0] = c;
          cmpMode = 2'(m);
          run_scan();
          read_res(4'h0);
          `CHK(r, {4'h0, c})
          `CHK(nRange, hit({4'h0, c}, lo, hi, cmpMode))
          `CHK(nSat, int'(c == 12'hFFF || c == 12'h000))
        end
      end
      lo = 16'($urandom_range(1, 12'h7FF));
      hi = 16'($urandom_range(12'h800, 12'hFFF));
      load_cfg(2);
    end
    limitIrqEn = 16'h0000;
    cmpMode = 2'h0;
    chanCode[0] = 12'h000;
    run_scan();
    `CHK(nRange, 0)
    chanDiff = 16'h0001;
    diffSigned = 1'b1;
    for (int k = 0; k < 5; k++) begin
      c = (k < 4) ? corner[k + 2] : 12'($urandom);
      chanCode[0] = c;
      run_scan();
      read_res(4'h0);
      `CHK(r, {{4{~c[11]}}, ~c[11], c[10:0]})
      `CHK(nSat, int'(c == 12'hFFF || c == 12'h000))
    end
    $display("test compare and format done");
    chanEnable = 16'h002A;
    lastChannel = 4'h3;
    chanAltRes = 16'h0008;
    chanDiff = 16'h0002;
    alternate_resolution_select = 1'($urandom);
    n = $urandom_range(51, 400);
    acqTimeNs = {16{16'(n)}};
    latency = 4'($urandom_range(6));
    run_scan();
    `CHK({convCh[0], convCh[1], 28'(convCh.size())}, 36'h13_0000002)
    `CHK({bitsSeen[0], bitsSeen[1]}, {3'h4, alternate_resolution_select})
    `CHK({diffSeen[0], diffSeen[1]}, 2'b10)
    `CHK(nEos, 1)
    `CHK(int'(acqMin >= (n + 49) / 50), 1)
    `CHK(eventChannel, 4'h3)
    continuous = 1'b1;
    run_scan();
    continuous = 1'b0;
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge clk_sys);
    repeat (3) @(negedge clk_sys);
    `CHK({nEos, 32'(convCh.size())}, {32'd2, 32'd4})
    chanEnable = 16'hFFFF;
    lastChannel = 4'hF;
    run_scan();
    `CHK({convCh[15], 28'(convCh.size())}, 32'hF000_0010)
    $display("test scan order done");
    do_reset();
    chanEnable = 16'h0005;
    lastChannel = 4'h2;
    chanAvg = 16'h0005;
    chanAltRes = 16'h0004;
    c = 12'($urandom);
    chanCode[0] = c;
    run_scan();
    read_res(4'h0);
    `CHK({convCh[0], convCh[1], convCh[2], 20'(convCh.size())}, 32'h002_00003)
    `CHK(r, {4'h0, c})
    n = $urandom_range(3, 16);
    load_cfg(n);
    cmpMode = 2'h2;
    limitIrqEn = 16'h0001;
    for (int m = 0; m < 2; m++) begin
      avgMode = 2'(m);
      ex = m ? 16'((n * c) >> $clog2(n)) : 16'(n * c);
      run_scan();
      read_res(4'h0);
      `CHK(convCh.size(), n + 1)
      `CHK(r, ex)
      `CHK(nRange, hit(ex, lo, hi, 2'h2))
    end
    $display("test sequential averaging done");
    do_reset();
    chanEnable = 16'h0003;
    lastChannel = 4'h1;
    chanAvg = 16'h0001;
    chanAltRes = 16'h0000;
    avgMode = 2'h2;
    c = 12'($urandom_range(12'hD00, 12'hFFF));
    chanCode[0] = c;
    load_cfg(20);
    for (int s = 1; s <= 20; s++) begin
      run_scan();
      `CHK(convCh.size(), 2)
      `CHK({nEos, chanValid[0]}, {32'd1, s == 20})
    end
    read_res(4'h0);
    `CHK(r, 16'(20 * c))
    $display("test interleaved averaging done");
    report_and_stop();
  end
endmodule : adc_scan_sequencer_avg_limits_tb_top

// ---- conv_core_model.sv ----
/*
  Behavioural converter core facing the scan sequencer.
  Assumes one convStart pulse per conversion; the bench sets the code of
  channel 0 only (other channels read zero) and sets the answer latency once.
*/
`timescale 1ns/1ps
module conv_core_model
  import scan_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic convStart,
  input wire logic [CH_W-1:0] muxChannel,
  input wire logic [3:0] latency,
  input wire logic [11:0] chanCode [NUM_CH],
  output logic convDone,
  output logic [11:0] convCode
);
  logic active;
  logic [3:0] cnt;
  logic [11:0] held;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      active <= 1'b0;
      cnt <= 4'h0;
      held <= 12'h000;
      convDone <= 1'b0;
      convCode <= 12'hA5A;
    end else begin
      convDone <= 1'b0;
      // Code is only meaningful with convDone, so it toggles otherwise
      convCode <= ~convCode;
      if (convStart) begin
        active <= 1'b1;
        cnt <= latency;
        held <= chanCode[muxChannel];
      end else if (active && cnt == 4'h0) begin
        active <= 1'b0;
        convDone <= 1'b1;
        convCode <= held;
      end else if (active) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : conv_core_model

// ---- result_mem.sv ----
/*
  Per-channel result store: one write port, registered read data.
  Assumes writes and reads come from the same clock domain.
*/
`timescale 1ns/1ps
module result_mem
  import scan_pkg::*;
(
  input wire logic clk_sys,
  input wire logic writeEn,
  input wire logic [CH_W-1:0] writeAddr,
  input wire logic [RES_W-1:0] writeData,
  input wire logic [CH_W-1:0] readAddr,
  output logic [RES_W-1:0] readData
);
  logic [RES_W-1:0] mem [NUM_CH];

  always_ff @(posedge clk_sys) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end
endmodule : result_mem

// ---- scan_pkg.sv ----
/*
  Constants for the scan sequencer: channel count, field widths, averaging
  and compare encodings, threshold defaults and timing.
  Assumes a single 20 MHz system clock.
*/
package scan_pkg;
  localparam int NUM_CH = 16;
  localparam int CH_W = 4;
  localparam int RES_W = 16;
  localparam int ACQ_W = 16;
  localparam int AVG_W = 9;
  localparam int CLK_NS = 50;
  localparam logic [AVG_W-1:0] AVG_COUNT_RST = 9'h002;
  localparam logic [11:0] LOW_LIMIT_RST = 12'h200;
  localparam logic [11:0] HIGH_LIMIT_RST = 12'hE00;
  localparam logic [15:0] SIGNED_MAX = 16'h07FF;
  localparam logic [15:0] SIGNED_MIN = 16'hF800;
  localparam logic [15:0] UNSIGNED_MAX = 16'h0FFF;
  localparam logic [15:0] UNSIGNED_MIN = 16'h0000;

  typedef enum logic [1:0] {
    AVG_SEQ_SUM = 2'b00,
    AVG_SEQ_FIXED = 2'b01,
    AVG_INTERLEAVED = 2'b10
  } avg_mode_t;

  typedef enum logic [1:0] {
    CMP_BELOW = 2'b00,
    CMP_INSIDE = 2'b01,
    CMP_ABOVE = 2'b10,
    CMP_OUTSIDE = 2'b11
  } cmp_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEEK = 3'b001,
    ST_ACQ = 3'b010,
    ST_CONV = 3'b011,
    ST_STORE = 3'b100
  } seq_state_t;
endpackage : scan_pkg

// ---- scan_sequencer.sv ----
/*
  Scan sequencer for a successive-approximation converter: steps enabled
  channels, times acquisition, drives the converter core, averages,
  and raises range, saturation and end-of-scan events.
  Assumes the converter core shows its 12-bit code only in the cycle of
  convDone; all config inputs are synchronous to clk_sys.
*/
`timescale 1ns/1ps
module scan_sequencer
  import scan_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic scanStart,
  input wire logic continuous,
  input wire logic [CH_W-1:0] lastChannel,
  input wire logic [NUM_CH-1:0] chanEnable,
  input wire logic [NUM_CH-1:0] chanAltRes,
  input wire logic [NUM_CH-1:0] chanDiff,
  input wire logic [NUM_CH-1:0] chanAvg,
  input wire logic [NUM_CH-1:0] limitIrqEn,
  input wire logic [NUM_CH-1:0] satIrqEn,
  input wire logic [NUM_CH*ACQ_W-1:0] acqTimeNs,
  input wire logic alternate_resolution_select,
  input wire logic [AVG_W-1:0] avgCount,
  input wire logic avgCountLoad,
  input wire logic [1:0] avgMode,
  input wire logic diffSigned,
  input wire logic seSigned,
  input wire logic [1:0] cmpMode,
  input wire logic [RES_W-1:0] lowLimitIn,
  input wire logic [RES_W-1:0] highLimitIn,
  input wire logic limitLoad,
  input wire logic convDone,
  input wire logic [11:0] convCode,
  input wire logic [CH_W-1:0] readChannel,
  output logic convStart,
  output logic [CH_W-1:0] muxChannel,
  output logic muxDiff,
  output logic sampling,
  output logic [1:0] convBits,
  output logic busy,
  output logic endOfScan,
  output logic rangeEvent,
  output logic satEvent,
  output logic [CH_W-1:0] eventChannel,
  output logic [NUM_CH-1:0] chanValid,
  output logic [RES_W-1:0] readResult
);
  seq_state_t state;
  logic [CH_W-1:0] chan;
  logic [ACQ_W-1:0] acqCnt;
  logic [AVG_W-1:0] sampleCnt;
  logic [AVG_W-1:0] avgCountReg;
  logic [RES_W-1:0] lowLimit;
  logic [RES_W-1:0] highLimit;
  logic [31:0] accum;
  logic [NUM_CH*AVG_W-1:0] scanCount;
  logic [NUM_CH*RES_W-1:0] interAcc;
  logic memWrite;
  logic [RES_W-1:0] memData;
  logic holdRun;
  logic [11:0] codeReg;

  // Lowest enabled channel at or above a starting index, up to the last
  function automatic logic [CH_W:0] next_enabled(
    input logic [NUM_CH-1:0] en,
    input logic [CH_W-1:0] from,
    input logic [CH_W-1:0] last
  );
    logic [CH_W:0] found;
    found = {1'b1, {CH_W{1'b0}}};
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (i >= from && i <= last && en[i]) begin
        found = {1'b0, CH_W'(i)};
      end
    end
    return found;
  endfunction : next_enabled

  // Acquisition time in ns to clock cycles, rounded up, never zero
  function automatic logic [ACQ_W-1:0] acq_cycles(input logic [ACQ_W-1:0] ns);
    logic [ACQ_W:0] cyc;
    cyc = (ACQ_W+1)'((32'(ns) + CLK_NS - 1) / CLK_NS);
    if (cyc == '0) begin
      cyc = (ACQ_W+1)'(1);
    end
    return cyc[ACQ_W-1:0];
  endfunction : acq_cycles

  wire anyNative = |(chanEnable & ~chanAltRes);
  wire chanAltNow = chanAltRes[chan];
  // Averaging only when the channel runs at the highest resolution in use
  wire avgAllowed = chanAvg[chan] && (!chanAltNow || !anyNative);
  wire interMode = avgMode == AVG_INTERLEAVED;
  wire seqAvg = avgAllowed && !interMode;
  wire interAvg = avgAllowed && interMode;
  wire [CH_W:0] firstHit = next_enabled(chanEnable, '0, lastChannel);
  wire [CH_W:0] nextHit = next_enabled(chanEnable, chan + 1'b1, lastChannel);
  wire lastOfScan = nextHit[CH_W] || chan == lastChannel;
  wire [ACQ_W-1:0] acqTarget = acq_cycles(acqTimeNs[chan*ACQ_W +: ACQ_W]);
  wire [AVG_W-1:0] chanScans = scanCount[chan*AVG_W +: AVG_W];
  wire [RES_W-1:0] chanInter = interAcc[chan*RES_W +: RES_W];
  wire isSigned = chanDiff[chan] ? diffSigned : seSigned;

  // Native or alternate code width, right-justified
  wire [3:0] resBits = !chanAltNow ? 4'hC
                     : (alternate_resolution_select ? 4'hA : 4'h8);
  wire [11:0] rawCode = codeReg >> (4'hC - resBits);
  wire [11:0] signBit = 12'h001 << (resBits - 4'h1);
  // Signed: flip top bit then sign-extend over 16 bits
  wire [11:0] flipped = rawCode ^ signBit;
  wire [RES_W-1:0] sampleVal = isSigned
    ? RES_W'($signed(flipped << (4'hC - resBits)) >>> (4'hC - resBits))
    : RES_W'(rawCode);

  // Shift to fit the total into the target width
  function automatic logic [4:0] log2_ceil(input logic [AVG_W-1:0] n);
    logic [4:0] r;
    r = '0;
    for (int b = 0; b < AVG_W; b++) begin
      if ((32'd1 << b) < 32'(n)) begin
        r = 5'(b + 1);
      end
    end
    return r;
  endfunction : log2_ceil

  wire [4:0] avgShift = log2_ceil(avgCountReg);
  wire [4:0] sumShift = avgShift > 5'd4 ? avgShift - 5'd4 : 5'd0;
  wire [31:0] seqSum = accum + 32'($signed(sampleVal));
  wire [RES_W-1:0] seqResult = (avgMode == AVG_SEQ_SUM)
    ? RES_W'($signed(seqSum) >>> sumShift)
    : RES_W'($signed(seqSum) >>> avgShift);
  // Interleaved: raw running sum, wrap allowed and unflagged
  wire [RES_W-1:0] interNext = (chanScans == '0 ? '0 : chanInter)
                             + sampleVal;
  wire lastSample = sampleCnt + 1'b1 >= avgCountReg;
  wire interDone = chanScans + 1'b1 >= avgCountReg;
  wire [RES_W-1:0] finalVal = seqAvg ? seqResult
                            : (interAvg ? interNext : sampleVal);

  // Saturation extremes for the channel's width and format
  wire [RES_W-1:0] satMax = isSigned ? (SIGNED_MAX >> (4'hC - resBits))
                                     : (UNSIGNED_MAX >> (4'hC - resBits));
  wire [RES_W-1:0] satMin = isSigned
    ? RES_W'($signed(SIGNED_MIN) >>> (4'hC - resBits)) : UNSIGNED_MIN;
  wire isSat = sampleVal == satMax || sampleVal == satMin;

  // Compare the final value; signed formats compare signed
  wire belowLow = isSigned ? $signed(finalVal) < $signed(lowLimit)
                           : finalVal < lowLimit;
  wire atHigh = isSigned ? $signed(finalVal) >= $signed(highLimit)
                         : finalVal >= highLimit;
  wire inRange = (cmpMode == CMP_BELOW) ? belowLow
               : (cmpMode == CMP_INSIDE) ? (!belowLow && !atHigh)
               : (cmpMode == CMP_ABOVE) ? atHigh
               : (belowLow || atHigh);

  wire finishing = state == ST_STORE && !(seqAvg && !lastSample);
  wire storeValid = finishing && (!interAvg || interDone);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avgCountReg <= AVG_COUNT_RST;
      lowLimit <= RES_W'(LOW_LIMIT_RST);
      highLimit <= RES_W'(HIGH_LIMIT_RST);
    end else begin
      if (avgCountLoad) begin
        avgCountReg <= (avgCount == '0) ? AVG_W'(1) : avgCount;
      end
      if (limitLoad) begin
        lowLimit <= lowLimitIn;
        highLimit <= highLimitIn;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      chan <= '0;
      acqCnt <= '0;
      sampleCnt <= '0;
      accum <= '0;
      holdRun <= 1'b0;
      codeReg <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (scanStart || holdRun) begin
            holdRun <= continuous;
            state <= ST_SEEK;
          end
        end
        ST_SEEK: begin
          if (firstHit[CH_W]) begin
            state <= ST_IDLE;
          end else begin
            chan <= firstHit[CH_W-1:0];
            acqCnt <= '0;
            sampleCnt <= '0;
            accum <= '0;
            state <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          acqCnt <= acqCnt + 1'b1;
          if (acqCnt + 1'b1 >= acqTarget) begin
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (convDone) begin
            // Core code is only valid alongside convDone
            codeReg <= convCode;
            state <= ST_STORE;
          end
        end
        ST_STORE: begin
          acqCnt <= '0;
          if (seqAvg && !lastSample) begin
            accum <= seqSum;
            sampleCnt <= sampleCnt + 1'b1;
            state <= ST_ACQ;
          end else if (lastOfScan) begin
            holdRun <= holdRun && continuous;
            state <= ST_IDLE;
          end else begin
            chan <= nextHit[CH_W-1:0];
            sampleCnt <= '0;
            accum <= '0;
            state <= ST_ACQ;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Per-channel interleaved scan counters and running sums
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        scanCount[g*AVG_W +: AVG_W] <= '0;
        interAcc[g*RES_W +: RES_W] <= '0;
        chanValid[g] <= 1'b0;
      end else if (finishing && chan == CH_W'(g)) begin
        if (interAvg) begin
          interAcc[g*RES_W +: RES_W] <= interNext;
          scanCount[g*AVG_W +: AVG_W] <= interDone ? '0 : chanScans + 1'b1;
        end
        chanValid[g] <= storeValid;
      end
    end
  end

  assign memWrite = storeValid;
  assign memData = finalVal;

  result_mem u_mem (
    .clk_sys(clk_sys),
    .writeEn(memWrite),
    .writeAddr(chan),
    .writeData(memData),
    .readAddr(readChannel),
    .readData(readResult)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      endOfScan <= 1'b0;
      rangeEvent <= 1'b0;
      satEvent <= 1'b0;
      eventChannel <= '0;
      convStart <= 1'b0;
    end else begin
      endOfScan <= finishing && lastOfScan;
      rangeEvent <= storeValid && limitIrqEn[chan] && inRange;
      satEvent <= finishing && satIrqEn[chan] && isSat;
      if (finishing) begin
        eventChannel <= chan;
      end
      convStart <= state == ST_ACQ && acqCnt + 1'b1 >= acqTarget;
    end
  end

  assign muxChannel = chan;
  assign muxDiff = chanDiff[chan];
  assign sampling = state == ST_ACQ;
  assign convBits = !chanAltNow ? 2'h2
                  : (alternate_resolution_select ? 2'h1 : 2'h0);
  assign busy = state != ST_IDLE;

  a_acq_before_conv: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(state == ST_CONV) |-> $past(acqCnt) + 1'b1 >= $past(acqTarget))
    else $error("conversion began before acquisition time");
  a_eos_pulse: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    endOfScan |-> $past(state) == ST_STORE ##1 !endOfScan)
    else $error("end of scan not a single pulse");
  a_skip_disabled: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    state == ST_ACQ |-> chanEnable[chan] && chan <= lastChannel)
    else $error("disabled channel acquired");
  a_avg_default: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !$past(avgCountLoad) && $past(arst_n) |-> $stable(avgCountReg))
    else $error("averaging count changed without load");
  a_range_masked: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    rangeEvent |-> limitIrqEn[eventChannel])
    else $error("range event on a masked channel");
  a_sat_masked: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    satEvent |-> satIrqEn[eventChannel])
    else $error("saturation event on a masked channel");
  a_seq_stays: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    state == ST_STORE && seqAvg && !lastSample
      |=> state == ST_ACQ && $stable(chan))
    else $error("sequencer left an averaged channel early");
  a_inter_valid: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    finishing && interAvg && !interDone |=> !chanValid[$past(chan)])
    else $error("interleaved channel valid before count reached");
endmodule : scan_sequencer
